// file: lbm_pkg.sv
// constants shared by the local-bus master control block: the control word
// map, its reset value and the counts used by the arbitration and transfer logic.
// assumes a single 16-bit control word reached from the host bus in bridge mode.
`default_nettype none

package lbm_pkg;

   localparam logic [7:0] CTRL_OFFSET = 8'h40;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // bits 7 and 12..15 are unused and never stored
   localparam logic [15:0] CTRL_WRITE_MASK = 16'h0F7F;

   localparam int CLKE_BIT = 0;
   localparam int ARBE_BIT = 1;
   localparam int LEN_LSB = 2;
   localparam int LEN_MSB = 5;
   localparam int WIDTH_BIT = 6;
   localparam int HOLD_LSB = 8;
   localparam int HOLD_MSB = 11;

   localparam logic [3:0] LEN_READY_CODE = 4'h0;
   localparam logic [3:0] LEN_MAX_CODE = 4'hB;
   localparam logic [4:0] READY_LIMIT = 5'h09;
   localparam logic [4:0] ACCESS_TIMEOUT = 5'h10;

   localparam int HOLD_TIMER_W = 21;
   localparam logic [20:0] MIN_HOLD_LEFT = 21'h000010;
   localparam logic [20:0] HOLD_BASE_CLOCKS = 21'h000020;

   typedef enum logic [2:0] {
      ARB_IDLE = 3'b001,
      ARB_REQ = 3'b010,
      ARB_HOLD = 3'b100
   } lbm_arb_t;

   typedef enum logic [1:0] {
      XFER_IDLE = 2'b01,
      XFER_RUN = 2'b10
   } lbm_xfer_t;

endpackage

`default_nettype wire

// file: lbm_sync.sv
// two-flop synchroniser for a group of pins, with a rising-edge pulse per bit.
// assumes inputs are asynchronous to clk; reset is synchronous, active low.
`default_nettype none

module lbm_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] rise
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   // meta_q feeds only sync_q
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign q = sync_q;
   assign rise = sync_q & ~prev_q;

endmodule // lbm_sync

`default_nettype wire

// file: lbm_master_control.sv
// local-bus master control: control word, bus arbitration and transfer timing.
// assumes the host register port and host access port run on REF_CLK, and that
// the local clock and all local-bus inputs are asynchronous and are synchronised.
//
// What this block does
// - control word reachable only in bridge mode
// - hardware reset zeroes word; soft reset ignored
// - bit 0 drives or floats local clock
// - bit 1 activates arbitration pins and handshake
// - hold timer runs only with arbitration enabled
// - length code zero: ready input ends transfer
// - codes 1 to 11: fixed clock-period length
// - bit 6 selects 8 or 16 bit bus
// - hold time counted from acknowledge to release
// - hold is 32 clocks doubled per code
// - request bus, await acknowledge, hold, release
// - already granted: transfer without new request
// - float address, data, strobes when not owner
// - no ready by ninth clock: abort, flag error
// - style select swaps request and strobe meanings
// - access without grant answered with retry
// - access needs grant and 16 clocks left
// - access reaching 16 clocks times out retry
`default_nettype none

module lbm_master_control #(
   parameter logic [20:0] HOLD_BASE = lbm_pkg::HOLD_BASE_CLOCKS
) (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic BRIDGE_MODE,
   input wire logic REG_SELECT,
   input wire logic REG_WRITE,
   input wire logic [7:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   output logic [15:0] REG_RDATA,
   input wire logic HOST_REQ,
   input wire logic HOST_WRITE,
   input wire logic [19:0] HOST_ADDR,
   input wire logic [15:0] HOST_WDATA,
   output logic HOST_DONE,
   output logic HOST_RETRY,
   output logic [15:0] HOST_RDATA,
   input wire logic ERROR_CLEAR,
   output logic LOCAL_ACCESS_ERROR_FLAG,
   input wire logic LOCAL_CLK_IN,
   output logic LOCAL_CLOCK_OUT,
   output logic LOCAL_CLOCK_OUT_OE_N,
   input wire logic BUS_STYLE_SELECT,
   output logic HOLD_REQUEST_OUT,
   output logic HOLD_REQUEST_OE_N,
   input wire logic HOLD_ACKNOWLEDGE_IN,
   output logic GRANT_ACKNOWLEDGE_N,
   output logic GRANT_ACKNOWLEDGE_OE_N,
   input wire logic EXTERNAL_READY_N,
   output logic [19:0] LOCAL_ADDRESS,
   output logic LOCAL_ADDRESS_OE_N,
   output logic [15:0] LOCAL_DATA_OUT,
   input wire logic [15:0] LOCAL_DATA_IN,
   output logic LOCAL_DATA_OE_N,
   output logic BYTE_HIGH_ENABLE_N,
   output logic BYTE_HIGH_ENABLE_OE_N,
   output logic WRITE_STROBE_N,
   output logic READ_STROBE_N,
   output logic STROBE_OE_N
);

   // synchronised pins
   logic [4:0] pins_s;
   logic [4:0] pins_rise;
   logic [15:0] data_s;
   logic local_clock_out_s;
   logic local_clock_out_rise;
   logic ack_s;
   logic ready_n_s;
   logic style_s;
   logic bridge_s;

   lbm_sync #(.W(5)) u_sync_pins (
      .clk(REF_CLK),
      .reset_n(RESET_N),
      .d({LOCAL_CLK_IN, HOLD_ACKNOWLEDGE_IN, EXTERNAL_READY_N, BUS_STYLE_SELECT, BRIDGE_MODE}),
      .q(pins_s),
      .rise(pins_rise)
   );

   lbm_sync #(.W(16)) u_sync_data (
      .clk(REF_CLK),
      .reset_n(RESET_N),
      .d(LOCAL_DATA_IN),
      .q(data_s),
      .rise()
   );

   assign local_clock_out_s = pins_s[4];
   assign local_clock_out_rise = pins_rise[4];
   assign ack_s = pins_s[3];
   assign ready_n_s = pins_s[2];
   assign style_s = pins_s[1];
   assign bridge_s = pins_s[0];

   // control word
   logic [15:0] ctrl_q;
   logic [15:0] ctrl_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic reg_hit;
   logic clk_en;
   logic arb_en;
   logic [3:0] len_code;
   logic ready_mode;
   logic width8;
   logic [3:0] hold_code;

   // configuration mode hides the word entirely
   assign reg_hit = REG_SELECT & bridge_s & (REG_ADDR == lbm_pkg::CTRL_OFFSET);
   assign ctrl_d = (reg_hit & REG_WRITE) ? (REG_WDATA & lbm_pkg::CTRL_WRITE_MASK) : ctrl_q;
   assign rdata_d = (REG_SELECT & ~REG_WRITE) ? (reg_hit ? ctrl_q : '0) : rdata_q;

   // only the hardware reset clears the word; no soft reset reaches it
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         ctrl_q <= lbm_pkg::CTRL_RESET;
         rdata_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA = rdata_q;
   assign clk_en = ctrl_q[lbm_pkg::CLKE_BIT];
   assign arb_en = ctrl_q[lbm_pkg::ARBE_BIT];
   assign len_code = ctrl_q[lbm_pkg::LEN_MSB:lbm_pkg::LEN_LSB];
   assign ready_mode = (len_code == lbm_pkg::LEN_READY_CODE);
   assign width8 = ctrl_q[lbm_pkg::WIDTH_BIT];
   assign hold_code = ctrl_q[lbm_pkg::HOLD_MSB:lbm_pkg::HOLD_LSB];

   // arbitration
   lbm_pkg::lbm_arb_t arb_q;
   lbm_pkg::lbm_arb_t arb_d;
   lbm_pkg::lbm_xfer_t xfer_q;
   lbm_pkg::lbm_xfer_t xfer_d;
   logic [20:0] timer_q;
   logic [20:0] timer_d;
   logic [20:0] hold_load;
   logic grant_seen;
   logic held;
   logic enough_left;
   logic bus_free;
   logic xfer_idle;
   logic host_go;
   logic host_refuse;

   assign grant_seen = style_s ? ~ack_s : ack_s;
   assign held = (arb_q == lbm_pkg::ARB_HOLD);
   assign xfer_idle = (xfer_q == lbm_pkg::XFER_IDLE);
   assign hold_load = HOLD_BASE << hold_code;
   assign enough_left = (timer_q >= lbm_pkg::MIN_HOLD_LEFT);
   assign bus_free = ~arb_en | (held & enough_left);
   assign host_go = HOST_REQ & xfer_idle & bus_free;
   assign host_refuse = HOST_REQ & ~host_go;

   always_comb begin
      arb_d = arb_q;
      unique case (arb_q)
         lbm_pkg::ARB_IDLE: begin
            if (HOST_REQ & arb_en) begin
               arb_d = lbm_pkg::ARB_REQ;
            end
         end
         lbm_pkg::ARB_REQ: begin
            if (grant_seen) begin
               arb_d = lbm_pkg::ARB_HOLD;
            end
         end
         lbm_pkg::ARB_HOLD: begin
            // a transfer in flight finishes before the bus is let go
            if ((timer_q == '0) & xfer_idle) begin
               arb_d = lbm_pkg::ARB_IDLE;
            end
         end
         default: arb_d = lbm_pkg::ARB_IDLE;
      endcase
      if (!arb_en) begin
         arb_d = lbm_pkg::ARB_IDLE;
      end
   end

   assign timer_d = !arb_en ? '0 :
      ((arb_q == lbm_pkg::ARB_REQ) & grant_seen) ? hold_load :
      (held & local_clock_out_rise & (timer_q != '0)) ? timer_q - 21'h000001 : timer_q;

   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         arb_q <= lbm_pkg::ARB_IDLE;
         timer_q <= '0;
      end else begin
         arb_q <= arb_d;
         timer_q <= timer_d;
      end
   end

   // transfer timing, counted in local clock rising edges
   logic [4:0] periods_q;
   logic [4:0] periods_d;
   logic [4:0] periods_next;
   logic end_fixed;
   logic end_ready;
   logic abort_ready;
   logic abort_wdog;
   logic finish;
   logic write_q;
   logic [19:0] addr_q;
   logic [15:0] wdata_q;
   logic bhe_n_q;
   logic done_q;
   logic retry_q;
   logic [15:0] hrdata_q;
   logic [15:0] hrdata_d;
   logic err_q;

   assign periods_next = periods_q + 5'h01;
   assign end_fixed = ~ready_mode & local_clock_out_rise & (len_code <= lbm_pkg::LEN_MAX_CODE)
      & (periods_next == {1'b0, len_code});
   assign end_ready = ready_mode & local_clock_out_rise & ~ready_n_s;
   assign abort_ready = ready_mode & local_clock_out_rise & ready_n_s
      & (periods_next == lbm_pkg::READY_LIMIT);
   // illegal length codes never end as fixed, so only the watchdog ends them
   assign abort_wdog = local_clock_out_rise & (periods_next == lbm_pkg::ACCESS_TIMEOUT);
   assign finish = (xfer_q == lbm_pkg::XFER_RUN)
      & (end_fixed | end_ready | abort_ready | abort_wdog);

   always_comb begin
      xfer_d = xfer_q;
      periods_d = periods_q;
      unique case (xfer_q)
         lbm_pkg::XFER_IDLE: begin
            if (host_go) begin
               xfer_d = lbm_pkg::XFER_RUN;
               periods_d = '0;
            end
         end
         lbm_pkg::XFER_RUN: begin
            if (finish) begin
               xfer_d = lbm_pkg::XFER_IDLE;
            end else if (local_clock_out_rise) begin
               periods_d = periods_next;
            end
         end
         default: xfer_d = lbm_pkg::XFER_IDLE;
      endcase
   end

   // 8-bit mode uses only the low data lanes
   assign hrdata_d = (finish & (end_fixed | end_ready) & ~write_q) ?
      (width8 ? {8'h00, data_s[7:0]} : data_s) : hrdata_q;

   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         xfer_q <= lbm_pkg::XFER_IDLE;
         periods_q <= '0;
         write_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= '0;
         bhe_n_q <= 1'b1;
      end else begin
         xfer_q <= xfer_d;
         periods_q <= periods_d;
         if (host_go) begin
            write_q <= HOST_WRITE;
            addr_q <= HOST_ADDR;
            wdata_q <= width8 ? {8'h00, HOST_WDATA[7:0]} : HOST_WDATA;
            bhe_n_q <= width8;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         done_q <= 1'b0;
         retry_q <= 1'b0;
         hrdata_q <= '0;
         err_q <= 1'b0;
      end else begin
         done_q <= finish & (end_fixed | end_ready);
         retry_q <= host_refuse | (finish & ~(end_fixed | end_ready));
         hrdata_q <= hrdata_d;
         // a new error in the clearing cycle is kept
         err_q <= (finish & abort_ready & ~end_fixed) | (err_q & ~ERROR_CLEAR);
      end
   end

   assign HOST_DONE = done_q;
   assign HOST_RETRY = retry_q;
   assign HOST_RDATA = hrdata_q;
   assign LOCAL_ACCESS_ERROR_FLAG = err_q;

   // pins
   logic own_bus;
   logic strobe_on;

   assign own_bus = ~arb_en | held;
   assign strobe_on = (xfer_q == lbm_pkg::XFER_RUN);

   assign LOCAL_CLOCK_OUT = local_clock_out_s;
   assign LOCAL_CLOCK_OUT_OE_N = ~clk_en;

   assign HOLD_REQUEST_OUT = style_s ? held | (arb_q == lbm_pkg::ARB_IDLE) :
      ~(arb_q == lbm_pkg::ARB_IDLE);
   assign HOLD_REQUEST_OE_N = ~arb_en;
   assign GRANT_ACKNOWLEDGE_N = ~held;
   assign GRANT_ACKNOWLEDGE_OE_N = ~arb_en;

   assign LOCAL_ADDRESS = addr_q;
   assign LOCAL_ADDRESS_OE_N = ~own_bus;
   assign LOCAL_DATA_OUT = wdata_q;
   assign LOCAL_DATA_OE_N = ~(own_bus & strobe_on & write_q);
   assign BYTE_HIGH_ENABLE_N = bhe_n_q;
   assign BYTE_HIGH_ENABLE_OE_N = ~own_bus;
   // style 1: first pin is read/write select, second is data strobe
   assign WRITE_STROBE_N = style_s ? ~write_q : ~(strobe_on & write_q);
   assign READ_STROBE_N = style_s ? ~strobe_on : ~(strobe_on & ~write_q);
   assign STROBE_OE_N = ~own_bus;

endmodule // lbm_master_control

`default_nettype wire

// file: lbm_properties.sv
// assertions on the ports of the local-bus master control block
// assumes Intel style strapping whenever arbitration is on; bound from the bench
`default_nettype none
module lbm_properties (
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic REG_SELECT,
   input wire logic REG_WRITE,
   input wire logic [7:0] REG_ADDR,
   input wire logic [15:0] REG_RDATA,
   input wire logic HOST_REQ,
   input wire logic HOST_RETRY,
   input wire logic LOCAL_ACCESS_ERROR_FLAG,
   input wire logic HOLD_REQUEST_OUT,
   input wire logic HOLD_REQUEST_OE_N,
   input wire logic GRANT_ACKNOWLEDGE_N,
   input wire logic GRANT_ACKNOWLEDGE_OE_N,
   input wire logic LOCAL_ADDRESS_OE_N,
   input wire logic STROBE_OE_N
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   property p_retry_pulse;
      HOST_RETRY |=> !HOST_RETRY;
   endproperty
   a_retry_pulse: assert property (p_retry_pulse) else $error("retry held");
   property p_refuse;
      HOST_REQ && !HOLD_REQUEST_OE_N && GRANT_ACKNOWLEDGE_N |=> HOST_RETRY;
   endproperty
   a_refuse: assert property (p_refuse) else $error("no retry");
   property p_request;
      HOST_REQ && !HOLD_REQUEST_OE_N && !HOLD_REQUEST_OUT |=> HOLD_REQUEST_OUT;
   endproperty
   a_request: assert property (p_request) else $error("no request");
   property p_arb_pins;
      HOLD_REQUEST_OE_N == GRANT_ACKNOWLEDGE_OE_N;
   endproperty
   a_arb_pins: assert property (p_arb_pins) else $error("arb pins differ");
   // one cycle of slack for the enables to follow a control write
   property p_float;
      (!GRANT_ACKNOWLEDGE_OE_N && GRANT_ACKNOWLEDGE_N) [*2] |-> LOCAL_ADDRESS_OE_N && STROBE_OE_N;
   endproperty
   a_float: assert property (p_float) else $error("bus driven");
   property p_release;
      $rose(GRANT_ACKNOWLEDGE_N) && !GRANT_ACKNOWLEDGE_OE_N |-> !HOLD_REQUEST_OUT;
   endproperty
   a_release: assert property (p_release) else $error("request kept");
   property p_err_cause;
      $rose(LOCAL_ACCESS_ERROR_FLAG) |-> HOST_RETRY;
   endproperty
   a_err_cause: assert property (p_err_cause) else $error("flag alone");
   property p_unmapped;
      REG_SELECT && !REG_WRITE && REG_ADDR != 8'h40 |=> REG_RDATA == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped data");
   property p_unused;
      REG_SELECT && !REG_WRITE |=> (REG_RDATA & 16'hF080) == 16'h0000;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits set");
endmodule // lbm_properties
`default_nettype wire

// file: lbm_partner.sv
// far side of the local bus: an arbiter and one peripheral
// assumes strobes arrive decoded to Intel sense; the clock runs free, released lines read as inactive
`default_nettype none
module lbm_partner #(
   parameter logic [15:0] RD_WORD = 16'hA55A
) (
   input wire logic grant_en,
   input wire logic [31:0] ready_at,
   input wire logic hold_req,
   input wire logic strobe_n,
   input wire logic read_n,
   output logic local_clock_out,
   output logic hold_ack,
   output logic ready_n,
   output logic [15:0] data
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt = 0;
   initial local_clock_out = 1'b0;
   initial hold_ack = 1'b0;
   initial ready_n = 1'b1;
   always #40 local_clock_out = ~local_clock_out;
   always @(posedge local_clock_out) begin
      hold_ack <= grant_en && hold_req;
   end
   // a released strobe restarts the count at once, so no count leaks into the next transfer
   always @(posedge local_clock_out or posedge strobe_n) begin
      if (strobe_n)
         cnt <= 0;
      else
         cnt <= cnt + 1;
   end
   // ready moves on the falling edge, clear of the rise that samples it;
   // ready_at of 0 never answers, to exercise the abort
   always @(negedge local_clock_out) begin
      ready_n <= !(ready_at != 0 && !strobe_n && cnt + 1 >= ready_at);
   end
   assign data = read_n ? ~RD_WORD : RD_WORD;
endmodule // lbm_partner
`default_nettype wire

// file: lbm_master_control_bench.sv
// self-checking bench for the local-bus master control block
// assumes lbm_partner as far side and lbm_properties bound as checker
`default_nettype none
module lbm_master_control_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] RD = 16'hA55A;
   logic clk, rst_n, bmode, sel, wr, hreq, hwr, done, retry, eclr, err, local_clock_out, lco_oe;
   logic hro, hro_oe, hack, gack, gack_oe, rdy, la_oe, ld_oe, bhe, ws, rs, st_oe, gnt, ok;
   logic style, lco, bhe_oe;
   logic [7:0] addr;
   logic [15:0] wd, rd, hwd, hrd, ldi, ldo;
   logic [19:0] haddr, la;
   int ready_at, n, m, check_count = 0, miscompares = 0, cyc = 0;
   lbm_master_control #(.HOLD_BASE(21'h000002)) i_dut (
      .REF_CLK(clk), .RESET_N(rst_n), .BRIDGE_MODE(bmode), .REG_SELECT(sel),
      .REG_WRITE(wr), .REG_ADDR(addr), .REG_WDATA(wd), .REG_RDATA(rd), .HOST_REQ(hreq),
      .HOST_WRITE(hwr), .HOST_ADDR(haddr), .HOST_WDATA(hwd), .HOST_DONE(done),
      .HOST_RETRY(retry), .HOST_RDATA(hrd), .ERROR_CLEAR(eclr),
      .LOCAL_ACCESS_ERROR_FLAG(err), .LOCAL_CLK_IN(local_clock_out), .LOCAL_CLOCK_OUT(lco),
      .LOCAL_CLOCK_OUT_OE_N(lco_oe), .BUS_STYLE_SELECT(style), .HOLD_REQUEST_OUT(hro),
      .HOLD_REQUEST_OE_N(hro_oe), .HOLD_ACKNOWLEDGE_IN(hack ^ style), .GRANT_ACKNOWLEDGE_N(gack),
      .GRANT_ACKNOWLEDGE_OE_N(gack_oe), .EXTERNAL_READY_N(rdy), .LOCAL_ADDRESS(la),
      .LOCAL_ADDRESS_OE_N(la_oe), .LOCAL_DATA_OUT(ldo), .LOCAL_DATA_IN(ldi),
      .LOCAL_DATA_OE_N(ld_oe), .BYTE_HIGH_ENABLE_N(bhe), .BYTE_HIGH_ENABLE_OE_N(bhe_oe),
      .WRITE_STROBE_N(ws), .READ_STROBE_N(rs), .STROBE_OE_N(st_oe));
   // floating request and strobes read as inactive; both styles decoded to Intel sense
   lbm_partner #(.RD_WORD(RD)) i_far (.grant_en(gnt), .ready_at(ready_at),
      .hold_req(!hro_oe & (hro ^ style)), .strobe_n(st_oe | (style ? rs : ws & rs)),
      .read_n(style ? rs | !ws : rs), .local_clock_out(local_clock_out), .hold_ack(hack), .ready_n(rdy), .data(ldi));
   always #2 clk = ~clk;
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic reg_io(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      #1 {sel, wr, addr, wd} = {1'b1, w, a, d};
      @(posedge clk);
      #1 sel = 1'b0;
   endtask
   task automatic host(input logic w);
      @(posedge clk);
      #1 {hreq, hwr} = {1'b1, w};
      @(posedge clk);
      #1 hreq = 1'b0;
      n = 1;
      while (done !== 1'b1 && retry !== 1'b1 && n < 1000) begin
         @(posedge clk);
         #1 n++;
      end
      ok = (done === 1'b1);
   endtask
   task automatic t_regs;
      reg_io(0, 8'h40, 0); chk("reset word", 16'h0000, rd);
      reg_io(1, 8'h40, 16'hFFAF); reg_io(0, 8'h40, 0); chk("word", 16'h0F2F, rd);
      reg_io(0, 8'h44, 0); chk("unmapped", 16'h0000, rd);
      bmode = 1'b0;
      repeat (4) @(posedge clk);
      reg_io(1, 8'h40, 16'h0001); reg_io(0, 8'h40, 0); chk("config read", 0, rd);
      bmode = 1'b1;
      repeat (4) @(posedge clk);
      reg_io(0, 8'h40, 0); chk("config write", 16'h0F2F, rd);
      $display("register test over");
   endtask
   task automatic t_fixed;
      for (int c = 1; c <= 11; c++) begin
         reg_io(1, 8'h40, {10'h000, c[3:0], 2'b01});
         host(0);
         chk("fixed done", 1, ok);
         chk("fixed length", 1, n >= (c - 1) * 20 + 1 && n <= c * 20 + 6);
      end
      chk("read word", RD, hrd);
      chk("clock driven", 0, lco_oe);
      @(posedge local_clock_out);
      repeat (4) @(posedge clk);
      #1 chk("clock out high", 1, lco);
      @(negedge local_clock_out);
      repeat (4) @(posedge clk);
      #1 chk("clock out low", 0, lco);
      reg_io(1, 8'h40, 16'h0048);
      host(0);
      chk("byte read", {8'h00, RD[7:0]}, hrd);
      chk("high enable", 1, bhe);
      chk("clock floated", 1, lco_oe);
      $display("fixed length test over");
   endtask
   task automatic t_ready;
      reg_io(1, 8'h40, 16'h0001);
      ready_at = 3; host(1); chk("ready done", 1, ok);
      chk("ready length", 1, n >= 41 && n <= 66);
      chk("address", 16'hA5A5, la[15:0]);
      chk("address top", 16'h0005, {12'h000, la[19:16]});
      chk("write data", 16'h3C96, ldo);
      chk("data released", 1, ld_oe);
      ready_at = 0; host(0); chk("abort", 1, retry === 1'b1 && !ok);
      chk("abort length", 1, n >= 161 && n <= 186);
      chk("error flag", 1, err);
      @(posedge clk);
      #1 eclr = 1'b1;
      @(posedge clk);
      #1 eclr = 1'b0;
      chk("error clear", 0, err);
      $display("ready test over");
   endtask
   task automatic t_arb;
      gnt = 1'b1;
      reg_io(1, 8'h40, 16'h0407);
      host(0); chk("refused", 1, retry === 1'b1 && n == 1);
      chk("request", 1, hro);
      chk("floating", 16'h0007, {la_oe, bhe_oe, st_oe});
      m = 0;
      while (gack !== 1'b0 && m < 500) begin
         @(posedge clk);
         #1 m++;
      end
      chk("grant", 0, gack);
      host(1); chk("granted access", 1, ok);
      m = n + 1;
      while (gack !== 1'b1 && m < 2000) begin
         @(posedge clk);
         #1 m++;
      end
      chk("hold length", 1, m >= 600 && m <= 680);
      chk("released", 0, hro);
      reg_io(1, 8'h40, 16'h0405);
      @(posedge clk);
      chk("arb floated", 16'h0003, {hro_oe, gack_oe});
      host(0); chk("direct access", 1, ok);
      $display("arbitration test over");
   endtask
   task automatic t_style;
      style = 1'b1;
      repeat (4) @(posedge clk);
      reg_io(1, 8'h40, 16'h0009);
      host(0); chk("style read", 1, ok);
      chk("style data", RD, hrd);
      chk("read select", 16'h0003, {ws, rs});
      host(1); chk("style write", 1, ok);
      chk("write select", 16'h0001, {ws, rs});
      $display("bus style test over");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      {clk, rst_n, sel, wr, hreq, hwr, eclr, gnt, style} = '0;
      {bmode, addr, wd, haddr, hwd, ready_at} = {1'b1, 8'h00, 16'h0000, 20'h5A5A5, 16'h3C96, 0};
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_fixed();
      t_ready();
      t_arb();
      t_style();
      test_done();
   end
endmodule // lbm_master_control_bench
bind lbm_master_control lbm_properties i_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
   .REG_SELECT(REG_SELECT), .REG_WRITE(REG_WRITE), .REG_ADDR(REG_ADDR),
   .REG_RDATA(REG_RDATA), .HOST_REQ(HOST_REQ), .HOST_RETRY(HOST_RETRY),
   .LOCAL_ACCESS_ERROR_FLAG(LOCAL_ACCESS_ERROR_FLAG), .HOLD_REQUEST_OUT(HOLD_REQUEST_OUT),
   .HOLD_REQUEST_OE_N(HOLD_REQUEST_OE_N), .GRANT_ACKNOWLEDGE_N(GRANT_ACKNOWLEDGE_N),
   .GRANT_ACKNOWLEDGE_OE_N(GRANT_ACKNOWLEDGE_OE_N), .LOCAL_ADDRESS_OE_N(LOCAL_ADDRESS_OE_N),
   .STROBE_OE_N(STROBE_OE_N));
`default_nettype wire
